// ==== verilog/tlm_map.svh ====
// Offsets, field positions, reset values and timing counts of the timer-load block.
`ifndef TLM_MAP_SVH
`define TLM_MAP_SVH
// -----------------------------------------------------------------------------
// Register byte offsets on APB
// -----------------------------------------------------------------------------
`define TLM_OFF_INSTR 12'h000
`define TLM_OFF_OPERAND 12'h004
`define TLM_OFF_TIMER 12'h008
`define TLM_OFF_MOD_A 12'h00c
`define TLM_OFF_MOD_B 12'h010
`define TLM_OFF_STATUS 12'h014
`define TLM_OFF_ROM_ADDR 12'h018
`define TLM_OFF_CAP_CFG 12'h01c
`define TLM_OFF_INPUTS 12'h020
// -----------------------------------------------------------------------------
// Field positions and values
// -----------------------------------------------------------------------------
`define TLM_ST_FLAG 0
`define TLM_ST_CARRY 1
`define TLM_ST_STANDBY 2
`define TLM_ST_VARIANT 3
`define TLM_ST_BUSY 4
`define TLM_CAP_ADDR 12'h043
`define TLM_CAP_ON 8'h01
`define TLM_CAP_OFF 8'h00
`define TLM_RST_10 10'h000
`define TLM_RST_4 4'h0
// -----------------------------------------------------------------------------
// Timing: oscillator periods per machine cycle and the revised-variant trim
// -----------------------------------------------------------------------------
`define TLM_OSC_PER_CYCLE 64
`define TLM_REV_TRIM 4
`endif

// ==== verilog/tlm_pkg.sv ====
// Types shared by the timer-load and miscellaneous instruction block.
package tlm_pkg;
    // Instruction codes written by software into the instruction register.
    typedef enum logic [3:0] {
        TLM_NOP = 4'h0,
        TLM_LD_T_IMM = 4'h1,
        TLM_LD_A_IMM = 4'h2,
        TLM_LD_B_IMM = 4'h3,
        TLM_LD_T_ROM = 4'h4,
        TLM_LD_A_ROM = 4'h5,
        TLM_LD_B_ROM = 4'h6,
        TLM_STANDBY = 4'h7,
        TLM_STATUS_TEST_OP_REG = 4'h8,
        TLM_STATUS_TEST_OP_IMM = 4'h9,
        TLM_CARRY_IF_ALL_ONES_OP = 4'ha,
        TLM_WR_HI = 4'hb,
        TLM_WR_LO = 4'hc
    } tlm_op_t;
    // Execution state.
    typedef enum logic [1:0] {
        TLM_IDLE = 2'b00,
        TLM_WAIT = 2'b01,
        TLM_EXEC = 2'b10
    } tlm_state_t;
    // Sensed statuses used by the status test.
    typedef struct packed {
        logic sense0;
        logic sense1;
        logic sense2;
        logic key_io;
        logic key_in;
        logic timer;
    } tlm_stat_t;
endpackage

// ==== verilog/tlm_core.sv ====
// Timer/modulo load, standby, status test, carry test and no-operation execution.
//
// Notes on behaviour
// - Immediate timer load fills all ten bits.
// - Interval (N+1)*64 osc periods, revised minus 4.
// - Immediate modulo loads replace all ten bits.
// - Table address: page bits over pointer pair.
// - Table load copies full ten-bit word.
// - Standby entered; nibble selects release conditions.
// - Register test compares five statuses to nibble.
// - Immediate test compares six statuses to nibble.
// - Flag set on any match, else cleared.
// - Carry set only when accumulator is 1111.
// - Accumulator keeps low ones, clears above zero.
// - Capacitor byte at 2043H: 01 on, 00 off.
// - Upper nibble write clears bit1, lower bit0.
// - Nibbles map to bits 9:6 and 5:2.
`timescale 1ns/1ps
`include "tlm_map.svh"
module tlm_core import tlm_pkg::*; #(
    parameter int PAGE_BITS = 2,
    parameter int PTR_BITS = 8,
    parameter bit REVISED = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PAGE_BITS-1:0] rom_page_select,
    input wire logic [PTR_BITS-1:0] pointer_pair,
    input wire logic [15:0][3:0] low_bank_reg,
    input wire logic [3:0] acc_in,
    output logic [PAGE_BITS+PTR_BITS-1:0] rom_addr,
    output logic rom_req,
    input wire logic [9:0] rom_data,
    input wire logic sense_input_0,
    input wire logic sense_input_1,
    input wire logic sense_input_2,
    input wire logic key_io_port,
    input wire logic key_input_port,
    input wire logic timer_status,
    output logic [9:0] timer_count_reg,
    output logic [9:0] modulo_reg_a,
    output logic [9:0] modulo_reg_b,
    output logic [3:0] acc_out,
    output logic carry_bit,
    output logic status_match_flag,
    output logic standby_reg,
    output logic [3:0] release_cond_reg,
    output logic pc_advance,
    output logic [16:0] timer_interval_osc
);
    // -------------------------------------------------------------------------
    // Helper functions
    // -------------------------------------------------------------------------
    // Place a nibble into bits 9:6 or 5:2 and clear bit 1 or bit 0.
    function automatic logic [9:0] nib_write(input logic [9:0] cur, input logic hi,
                                             input logic [3:0] n);
        logic [9:0] r;
        r = cur;
        if (hi) begin
            r[9:6] = n;
            r[1] = 1'b0;
        end else begin
            r[5:2] = n;
            r[0] = 1'b0;
        end
        return r;
    endfunction

    // Keep the unbroken run of low-order ones, clear everything above it.
    function automatic logic [3:0] low_ones(input logic [3:0] a);
        logic [3:0] r;
        r = 4'h0;
        if (a[0]) r[0] = 1'b1;
        if (a[1:0] == 2'b11) r[1] = 1'b1;
        if (a[2:0] == 3'b111) r[2] = 1'b1;
        if (a == 4'hf) r[3] = 1'b1;
        return r;
    endfunction

    // -------------------------------------------------------------------------
    // Input synchronisers for pins
    // -------------------------------------------------------------------------
    logic [5:0] pin_s1_reg; // First stage, read only by the second.
    logic [5:0] pin_s2_reg; // Stable pin levels.
    tlm_stat_t stat; // Synchronised statuses.

    // Two flip-flops ahead of any logic for each sensed pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 6'h00;
            pin_s2_reg <= 6'h00;
        end else begin
            pin_s1_reg <= {sense_input_0, sense_input_1, sense_input_2,
                           key_io_port, key_input_port, timer_status};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign stat = tlm_stat_t'(pin_s2_reg);

    // -------------------------------------------------------------------------
    // APB slave
    // -------------------------------------------------------------------------
    logic [3:0] instr_reg; // Pending instruction code.
    logic [9:0] operand_reg; // Immediate operand.
    logic [7:0] cap_cfg_reg; // Oscillator capacitor option byte.
    tlm_state_t state_reg; // Execution state.
    logic wr_en; // Write access phase.
    logic go; // Instruction issue pulse.
    logic addr_ok; // Mapped address.

    assign wr_en = psel && penable && pwrite;
    assign go = wr_en && paddr == `TLM_OFF_INSTR;
    assign pready = 1'b1;
    assign addr_ok = paddr == `TLM_OFF_INSTR || paddr == `TLM_OFF_OPERAND ||
                     paddr == `TLM_OFF_TIMER || paddr == `TLM_OFF_MOD_A ||
                     paddr == `TLM_OFF_MOD_B || paddr == `TLM_OFF_STATUS ||
                     paddr == `TLM_OFF_ROM_ADDR || paddr == `TLM_OFF_CAP_CFG ||
                     paddr == `TLM_OFF_INPUTS;
    assign pslverr = psel && penable && !addr_ok;

    // Software writes of the instruction, operand and capacitor option.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_reg <= `TLM_RST_4;
            operand_reg <= `TLM_RST_10;
            cap_cfg_reg <= `TLM_CAP_OFF;
        end else if (wr_en) begin
            if (paddr == `TLM_OFF_INSTR) instr_reg <= pwdata[3:0];
            if (paddr == `TLM_OFF_OPERAND) operand_reg <= pwdata[9:0];
            if (paddr == `TLM_OFF_CAP_CFG && pwdata[7:0] <= `TLM_CAP_ON) begin
                cap_cfg_reg <= pwdata[7:0];
            end
        end
    end

    // Read mux; unmapped addresses read as zero with an error.
    always_comb begin
        prdata = 32'h0;
        unique case (paddr)
            `TLM_OFF_INSTR: prdata = {28'h0, instr_reg};
            `TLM_OFF_OPERAND: prdata = {22'h0, operand_reg};
            `TLM_OFF_TIMER: prdata = {22'h0, timer_count_reg};
            `TLM_OFF_MOD_A: prdata = {22'h0, modulo_reg_a};
            `TLM_OFF_MOD_B: prdata = {22'h0, modulo_reg_b};
            `TLM_OFF_STATUS: prdata = {23'h0, release_cond_reg, state_reg != TLM_IDLE,
                                       REVISED, standby_reg, carry_bit,
                                       status_match_flag};
            `TLM_OFF_ROM_ADDR: prdata = 32'(rom_addr);
            `TLM_OFF_CAP_CFG: prdata = {24'h0, cap_cfg_reg};
            `TLM_OFF_INPUTS: prdata = {26'h0, pin_s2_reg};
            default: prdata = 32'h0;
        endcase
    end

    // -------------------------------------------------------------------------
    // Sequencer: a table load spends one cycle fetching, others execute at once
    // -------------------------------------------------------------------------
    tlm_op_t op; // Decoded instruction.
    logic is_rom; // Instruction needs a table word.
    assign op = tlm_op_t'(instr_reg);
    assign is_rom = op == TLM_LD_T_ROM || op == TLM_LD_A_ROM || op == TLM_LD_B_ROM;

    // Issue goes to fetch or execute; execute lasts a single cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= TLM_IDLE;
        end else begin
            unique case (state_reg)
                TLM_IDLE: if (go) state_reg <= TLM_EXEC;
                TLM_EXEC: state_reg <= is_rom ? TLM_WAIT : TLM_IDLE;
                TLM_WAIT: state_reg <= TLM_IDLE;
                default: state_reg <= TLM_IDLE;
            endcase
        end
    end

    logic exec; // Non-table instruction executes this cycle.
    logic rom_exec; // Table word is valid this cycle.
    assign exec = state_reg == TLM_EXEC && !is_rom;
    assign rom_exec = state_reg == TLM_WAIT;
    assign rom_req = state_reg == TLM_EXEC && is_rom;
    assign rom_addr = {rom_page_select, pointer_pair};
    assign pc_advance = exec || rom_exec;

    // -------------------------------------------------------------------------
    // Timer and modulo registers
    // -------------------------------------------------------------------------
    // Each load lands at the end of its cycle, so the next instruction sees it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count_reg <= `TLM_RST_10;
            modulo_reg_a <= `TLM_RST_10;
            modulo_reg_b <= `TLM_RST_10;
        end else if (exec) begin
            unique case (op)
                TLM_LD_T_IMM: timer_count_reg <= operand_reg;
                TLM_LD_A_IMM: modulo_reg_a <= operand_reg;
                TLM_LD_B_IMM: modulo_reg_b <= operand_reg;
                TLM_WR_HI, TLM_WR_LO: begin
                    unique case (operand_reg[9:8])
                        2'd0: timer_count_reg <= nib_write(timer_count_reg,
                                                 op == TLM_WR_HI, operand_reg[3:0]);
                        2'd1: modulo_reg_a <= nib_write(modulo_reg_a,
                                              op == TLM_WR_HI, operand_reg[3:0]);
                        default: modulo_reg_b <= nib_write(modulo_reg_b,
                                                 op == TLM_WR_HI, operand_reg[3:0]);
                    endcase
                end
                default: ; // NOP and others leave these alone.
            endcase
        end else if (rom_exec) begin
            unique case (op)
                TLM_LD_T_ROM: timer_count_reg <= rom_data;
                TLM_LD_A_ROM: modulo_reg_a <= rom_data;
                default: modulo_reg_b <= rom_data;
            endcase
        end
    end

    // Interval in oscillator periods for the loaded count.
    assign timer_interval_osc = 17'((32'(timer_count_reg) + 1) * `TLM_OSC_PER_CYCLE
                                - (REVISED ? `TLM_REV_TRIM : 0));

    // -------------------------------------------------------------------------
    // Standby, status test and carry test
    // -------------------------------------------------------------------------
    logic [3:0] sel_nib; // Selection nibble for the test.
    logic reg_hit; // Register-form match.
    logic imm_hit; // Immediate-form match.
    assign sel_nib = low_bank_reg[operand_reg[3:0]];
    // Register form: sense0, sense1, key ports and timer (no sense2).
    assign reg_hit = (sel_nib[0] && (stat.sense0 || stat.sense1)) ||
                     (sel_nib[1] && stat.key_io) || (sel_nib[2] && stat.key_in) ||
                     (sel_nib[3] && stat.timer);
    // Immediate form adds sense2 to the sense group.
    assign imm_hit = (operand_reg[0] && (stat.sense0 || stat.sense1 || stat.sense2)) ||
                     (operand_reg[1] && stat.key_io) || (operand_reg[2] && stat.key_in) ||
                     (operand_reg[3] && stat.timer);

    // Flags and accumulator result.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_match_flag <= 1'b0;
            carry_bit <= 1'b0;
            acc_out <= `TLM_RST_4;
            standby_reg <= 1'b0;
            release_cond_reg <= `TLM_RST_4;
        end else if (exec) begin
            unique case (op)
                TLM_STANDBY: begin
                    standby_reg <= 1'b1;
                    release_cond_reg <= operand_reg[3:0];
                end
                TLM_STATUS_TEST_OP_REG: status_match_flag <= reg_hit;
                TLM_STATUS_TEST_OP_IMM: status_match_flag <= imm_hit;
                TLM_CARRY_IF_ALL_ONES_OP: begin
                    carry_bit <= acc_in == 4'hf;
                    acc_out <= low_ones(acc_in);
                end
                default: standby_reg <= 1'b0;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    sequence s_issue_imm;
        state_reg == TLM_EXEC && !is_rom;
    endsequence
    property p_timer_imm;
        @(posedge pclk) disable iff (!presetn)
        (s_issue_imm and op == TLM_LD_T_IMM) |=> timer_count_reg == $past(operand_reg);
    endproperty
    a_timer_imm: assert property (p_timer_imm) else $error("timer immediate load wrong");
    property p_interval;
        @(posedge pclk) disable iff (!presetn)
        timer_interval_osc == 17'((32'(timer_count_reg) + 1) * 64 - (REVISED ? 4 : 0));
    endproperty
    a_interval: assert property (p_interval) else $error("timer interval wrong");
    property p_mod_a;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_LD_A_IMM) |=> modulo_reg_a == $past(operand_reg);
    endproperty
    a_mod_a: assert property (p_mod_a) else $error("modulo a load wrong");
    property p_rom_load;
        @(posedge pclk) disable iff (!presetn)
        (rom_req && op == TLM_LD_T_ROM) |=> ##1 timer_count_reg == $past(rom_data);
    endproperty
    a_rom_load: assert property (p_rom_load) else $error("table load wrong");
    property p_standby;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_STANDBY) |=> standby_reg && release_cond_reg == $past(operand_reg[3:0]);
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");
    property p_flag;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_STATUS_TEST_OP_IMM) |=> status_match_flag == $past(imm_hit);
    endproperty
    a_flag: assert property (p_flag) else $error("status flag wrong");
    property p_carry;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_CARRY_IF_ALL_ONES_OP) |=> carry_bit == ($past(acc_in) == 4'hf) &&
                                      (acc_out == 4'hf) == carry_bit;
    endproperty
    a_carry: assert property (p_carry) else $error("carry test wrong");
    property p_nop;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_NOP) |=> $stable(timer_count_reg) && $stable(carry_bit) &&
                                     $stable(status_match_flag);
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");
    property p_nib_timer;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_WR_HI && operand_reg[9:8] == 2'd0) |=>
            timer_count_reg[9:6] == $past(operand_reg[3:0]) && !timer_count_reg[1];
    endproperty
    a_nib_timer: assert property (p_nib_timer) else $error("upper nibble write wrong");
    property p_nib_mod_a;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_WR_LO && operand_reg[9:8] == 2'd1) |=>
            modulo_reg_a[5:2] == $past(operand_reg[3:0]) && !modulo_reg_a[0];
    endproperty
    a_nib_mod_a: assert property (p_nib_mod_a) else $error("lower nibble write wrong");
    property p_flag_reg;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_STATUS_TEST_OP_REG) |=> status_match_flag == $past(reg_hit);
    endproperty
    a_flag_reg: assert property (p_flag_reg) else $error("register status test wrong");
    // A table load into modulo A: fetch cycle, then the word lands one cycle later.
    sequence s_fetch_a;
        rom_req && op == TLM_LD_A_ROM;
    endsequence
    property p_rom_mod_a;
        @(posedge pclk) disable iff (!presetn)
        s_fetch_a |=> ##1 modulo_reg_a == $past(rom_data);
    endproperty
    a_rom_mod_a: assert property (p_rom_mod_a) else $error("table load into modulo a wrong");
    property p_acc;
        @(posedge pclk) disable iff (!presetn)
        (exec && op == TLM_CARRY_IF_ALL_ONES_OP) |=> acc_out == ($past(acc_in) & ~($past(acc_in) + 4'h1));
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator after carry test wrong");
endmodule

// ==== tb/timer_load_and_misc_instructions_bench.sv ====
// Self-checking bench for the timer-load and miscellaneous instruction block.
`timescale 1ns/1ps
`include "tlm_map.svh"
module timer_load_and_misc_instructions_bench import tlm_pkg::*;;
    // -------------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rom_req;
    logic standby_reg, carry_bit, status_match_flag, pc_advance, err;
    logic sense_input_0, sense_input_1, sense_input_2, key_io_port, key_input_port, timer_status;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] rom_page_select;
    logic [7:0] pointer_pair;
    logic [15:0][3:0] low_bank_reg;
    logic [3:0] acc_in, acc_out, release_cond_reg, e4, sel;
    logic [9:0] rom_addr, rom_data, timer_count_reg, modulo_reg_a, modulo_reg_b, seen_addr, v;
    logic [16:0] timer_interval_osc;
    logic [9:0] mreg [3]; // Model copies of timer, modulo A and modulo B.
    int fails, check_count, cycles, pulses, p0;

    tlm_core #(.PAGE_BITS(2), .PTR_BITS(8), .REVISED(1'b0)) dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rom_page_select, .pointer_pair, .low_bank_reg, .acc_in, .rom_addr,
        .rom_req, .rom_data, .sense_input_0, .sense_input_1, .sense_input_2, .key_io_port,
        .key_input_port, .timer_status, .timer_count_reg, .modulo_reg_a, .modulo_reg_b,
        .acc_out, .carry_bit, .status_match_flag, .standby_reg, .release_cond_reg,
        .pc_advance, .timer_interval_osc);

    // Free-running 100 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Table memory answers one cycle after the fetch strobe, otherwise shows changing data.
    function automatic logic [9:0] rom_word(input logic [9:0] a);
        return {a[1:0], a[9:2]} ^ 10'h2a5;
    endfunction
    always @(posedge pclk) begin
        if (rom_req === 1'b1) begin
            rom_data <= rom_word(rom_addr);
            seen_addr <= rom_addr;
        end else begin
            rom_data <= ~rom_data;
        end
        if (pc_advance === 1'b1) begin
            pulses <= pulses + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end

    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    // Compares one result with the model and counts it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; read data and error are taken at the pready edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Issues one instruction, waits while busy and checks one completion pulse.
    task automatic exec(input logic [3:0] op, input logic [9:0] opnd);
        int n = 0;
        p0 = pulses;
        apb(1'b1, `TLM_OFF_OPERAND, {22'h0, opnd});
        apb(1'b1, `TLM_OFF_INSTR, {28'h0, op});
        rd = 32'h10;
        while (rd[`TLM_ST_BUSY] !== 1'b0 && n < 20) begin
            apb(1'b0, `TLM_OFF_STATUS, 32'h0);
            n++;
        end
        chk("pc_advance pulses", p0 + 1, pulses);
    endtask

    // Compares the three loadable registers, on the pins and over the bus.
    task automatic chk_regs;
        chk("timer_count_reg", mreg[0], timer_count_reg);
        chk("modulo_reg_a", mreg[1], modulo_reg_a);
        chk("modulo_reg_b", mreg[2], modulo_reg_b);
        apb(1'b0, `TLM_OFF_TIMER, 32'h0);
        chk("timer read", mreg[0], rd);
        apb(1'b0, `TLM_OFF_MOD_A, 32'h0);
        chk("modulo a read", mreg[1], rd);
        apb(1'b0, `TLM_OFF_MOD_B, 32'h0);
        chk("modulo b read", mreg[2], rd);
    endtask

    // Prints the verdict and ends the run.
    task automatic summarize;
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, acc_in} = '0;
        {sense_input_0, sense_input_1, sense_input_2, key_io_port} = '0;
        {key_input_port, timer_status, rom_page_select, pointer_pair, low_bank_reg} = '0;
        rom_data = 10'h155;
        {fails, check_count, cycles, pulses} = '0;
        mreg = '{default: 10'h000};
        void'($urandom(32'h9ef9));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset state, then an unmapped access that must be refused.
        chk_regs();
        apb(1'b0, 12'h024, 32'h0);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, rd);
        // Immediate and table loads, with boundary values first.
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 3; k++) begin
                v = (r == 0) ? 10'h3ff : (r == 1) ? 10'h000 : 10'($urandom % 256);
                exec(4'(1 + k), v);
                mreg[k] = v;
                chk_regs();
                if (k == 0) begin
                    chk("interval", (v + 1) * 64, timer_interval_osc);
                end
                {rom_page_select, pointer_pair} <= 10'($urandom);
                @(posedge pclk);
                exec(4'(4 + k), 10'h0);
                mreg[k] = rom_word({rom_page_select, pointer_pair});
                chk("table address", {rom_page_select, pointer_pair}, seen_addr);
                chk_regs();
            end
        end
        // Nibble writes into upper and lower parts of each register.
        for (int i = 0; i < 6; i++) begin
            e4 = 4'($urandom);
            exec((i < 3) ? 4'hb : 4'hc, {2'(i % 3), 4'h0, e4});
            if (i < 3) begin
                mreg[i % 3] = {e4, mreg[i % 3][5:2], 1'b0, mreg[i % 3][0]};
            end else begin
                mreg[i % 3] = {mreg[i % 3][9:6], e4, mreg[i % 3][1], 1'b0};
            end
            chk_regs();
        end
        // Carry test over every accumulator value.
        for (int a = 0; a < 16; a++) begin
            acc_in <= 4'(a);
            @(posedge pclk);
            exec(4'ha, 10'h0);
            e4 = 4'(a) & ~(4'(a) + 4'h1);
            chk("carry_bit", a == 15, carry_bit);
            chk("acc_out", e4, acc_out);
        end
        // Standby with every release nibble.
        for (int d = 0; d < 16; d++) begin
            exec(4'h7, 10'(d));
            chk("standby_reg", 1, standby_reg);
            chk("release_cond_reg", d, release_cond_reg);
            apb(1'b0, `TLM_OFF_STATUS, 32'h0);
            chk("status release", {d[3:0], 1'b0, 1'b0, 1'b1}, rd[8:2]);
        end
        // Status tests in both forms, every selection nibble in the immediate form, random bank nibbles in the register form.
        for (int i = 0; i < 16; i++) begin
            {sense_input_0, sense_input_1, sense_input_2} <= 3'($urandom);
            {key_io_port, key_input_port, timer_status} <= 3'($urandom);
            low_bank_reg <= 64'({$urandom, $urandom});
            repeat (5) @(posedge pclk);
            sel = 4'(i);
            exec(4'h9, {6'h0, sel});
            chk("flag immediate", |(sel & {timer_status, key_input_port, key_io_port,
                sense_input_0 | sense_input_1 | sense_input_2}), status_match_flag);
            sel = 4'($urandom);
            exec(4'h8, {6'h0, sel});
            chk("flag register", |(low_bank_reg[sel] & {timer_status, key_input_port,
                key_io_port, sense_input_0 | sense_input_1}), status_match_flag);
        end
        // No-operation leaves loads, carry, flag and accumulator alone.
        e4 = acc_out;
        v = {8'h0, carry_bit, status_match_flag};
        exec(4'h0, 10'h0);
        chk_regs();
        chk("nop state", {v[1:0], e4}, {carry_bit, status_match_flag, acc_out});
        // Capacitor option byte: on, refused value, off.
        apb(1'b1, `TLM_OFF_CAP_CFG, 32'h1);
        apb(1'b0, `TLM_OFF_CAP_CFG, 32'h0);
        chk("cap on", `TLM_CAP_ON, rd);
        apb(1'b1, `TLM_OFF_CAP_CFG, 32'h2);
        apb(1'b0, `TLM_OFF_CAP_CFG, 32'h0);
        chk("cap ignored", `TLM_CAP_ON, rd);
        apb(1'b1, `TLM_OFF_CAP_CFG, 32'h0);
        apb(1'b0, `TLM_OFF_CAP_CFG, 32'h0);
        chk("cap off", `TLM_CAP_OFF, rd);
        summarize();
    end
endmodule
